// ==== cal_core.sv ====
// Command authentication latch: frame checks, command decode, latched outputs, telemetry
//
// Operation
// - Counterless mode: all three identifiers must match
// - Configuration bit turns counter checking off
// - Counter mode: received exceeds stored, then stored
// - One stored counter per allowed sender
// - Stored counters cleared to zero at power-up
// - Target and allowed senders loaded before mission
// - Unprimed destruct rejected, counter left alone
// - Six-bit code; zero is default; prime code
// - Destruct asserts only while prime is latched
// - Counter-clear code zeroes stored counter values
// - Auxiliary, test and receiver-disable codes decoded
// - Prime, destruct, auxiliary latched until default
// - All command outputs inactive after power returns
// - Five-bit user field, default zero
// - Accepted data valid one frame period
// - Validity flag travels with external data
// - User field authenticated like command field
// - User output held until next authenticated
// - Decode-valid bit when addressed and valid
// - Telemetry each frame: status, sender, counter
// - Twenty-bit target must equal own value
// - Sixteen-bit site, one accepted value
// - Twelve-bit counter carried in each frame
// - Check output held 20 ms, then low
`timescale 1ns/1ps
`default_nettype none

module cal_core #(
    parameter int FRAME_CYCLES = cal_pkg::FRAME_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Configuration from non-volatile store
    input wire logic cfg_load,
    input wire logic [cal_pkg::TARGET_W-1:0] cfg_target_identifier,
    input wire logic [cal_pkg::SITE_W-1:0] cfg_site_identifier,
    input wire logic [cal_pkg::SENDER_N-1:0] cfg_sender_allow,
    input wire logic cfg_counter_en,
    // Decoded frames
    input wire logic frame_stb,
    input wire cal_pkg::cal_frame_s frame_in,
    output logic frame_ready,
    // Command outputs
    output logic prime_out,
    output logic destruct_out,
    output logic aux_out,
    output logic test_out,
    output logic rx_disabled,
    output logic check_out,
    // User field and external interface
    output logic [cal_pkg::USER_W-1:0] user_out,
    output logic data_valid,
    // Status and telemetry
    output logic decode_valid,
    output cal_pkg::cal_tlm_s tlm_out,
    output logic tlm_stb
);

    localparam int TMR_W = $clog2(FRAME_CYCLES + 1);
    localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(FRAME_CYCLES);

    // ****************************************
    // Configuration
    // ****************************************
    logic [cal_pkg::TARGET_W-1:0] target_reg;
    logic [cal_pkg::SITE_W-1:0] site_reg;
    logic [cal_pkg::SENDER_N-1:0] allow_reg;
    logic ctr_en_reg;

    // Latched only on load so a glitch on the store lines mid-flight cannot retarget
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            target_reg <= cal_pkg::TARGET_RST;
            site_reg <= cal_pkg::SITE_RST;
            allow_reg <= cal_pkg::ALLOW_RST;
            ctr_en_reg <= 1'b0;
        end else if (cfg_load) begin
            target_reg <= cfg_target_identifier;
            site_reg <= cfg_site_identifier;
            allow_reg <= cfg_sender_allow;
            ctr_en_reg <= cfg_counter_en;
        end
    end

    // ****************************************
    // Frame capture and sequencing
    // ****************************************
    cal_pkg::cal_state_e state_reg;
    cal_pkg::cal_frame_s frame_reg;
    logic [cal_pkg::CTR_W-1:0] stored_ctr;

    assign frame_ready = (state_reg == cal_pkg::ST_IDLE);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= cal_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                cal_pkg::ST_IDLE: begin
                    if (frame_stb) begin
                        state_reg <= cal_pkg::ST_EVAL;
                    end
                end
                cal_pkg::ST_EVAL: begin
                    state_reg <= cal_pkg::ST_IDLE;
                end
                default: begin
                    state_reg <= cal_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            frame_reg <= '0;
        end else if (frame_ready && frame_stb) begin
            frame_reg <= frame_in;
        end
    end

    // ****************************************
    // Authentication
    // ****************************************
    logic eval;
    logic site_ok;
    logic target_ok;
    logic sender_ok;
    logic ids_ok;
    logic ctr_ok;
    logic code_known;
    logic destruct_blocked;
    logic auth;
    logic [cal_pkg::CMD_W-1:0] cmd;

    assign eval = (state_reg == cal_pkg::ST_EVAL) && !rx_disabled;
    assign cmd = frame_reg.command;
    assign site_ok = (frame_reg.site_identifier == site_reg);
    // A zero target is the null address and never selects this unit
    assign target_ok = (frame_reg.target_identifier == target_reg)
        && (target_reg != cal_pkg::TARGET_RST);
    assign sender_ok = allow_reg[frame_reg.sender_identifier];
    assign ids_ok = site_ok && target_ok && sender_ok;
    // Unsigned compare; wrap-around is the sender's problem
    assign ctr_ok = !ctr_en_reg || (frame_reg.counter > stored_ctr);

    always_comb begin
        case (cmd)
            cal_pkg::CMD_DEFAULT,
            cal_pkg::CMD_AUX,
            cal_pkg::CMD_PRIME,
            cal_pkg::CMD_DESTRUCT,
            cal_pkg::CMD_TEST,
            cal_pkg::CMD_DISABLE,
            cal_pkg::CMD_CTR_CLEAR: code_known = 1'b1;
            default: code_known = 1'b0;
        endcase
    end

    assign destruct_blocked = (cmd == cal_pkg::CMD_DESTRUCT) && !prime_out;
    assign auth = eval && ids_ok && ctr_ok && code_known && !destruct_blocked;

    // ****************************************
    // Per-sender counter store
    // ****************************************
    logic ctr_wr;
    logic ctr_clr;

    assign ctr_clr = auth && (cmd == cal_pkg::CMD_CTR_CLEAR);
    assign ctr_wr = auth && ctr_en_reg && !ctr_clr;

    cal_ctr_mem #(
        .WIDTH(cal_pkg::CTR_W),
        .ADDR_W(cal_pkg::SENDER_W)
    ) cal_ctr_mem_inst (
        .mclk(mclk),
        .rst_n(rst_n),
        .clr_all(ctr_clr),
        .wr_en(ctr_wr),
        .wr_addr(frame_reg.sender_identifier),
        .wr_data(frame_reg.counter),
        .rd_addr(frame_in.sender_identifier),
        .rd_data(stored_ctr)
    );

    // ****************************************
    // Latched command outputs
    // ****************************************
    // Synchronous reset brings every output low when power returns
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prime_out <= 1'b0;
            destruct_out <= 1'b0;
            aux_out <= 1'b0;
            test_out <= 1'b0;
        end else if (auth) begin
            case (cmd)
                cal_pkg::CMD_DEFAULT: begin
                    prime_out <= 1'b0;
                    destruct_out <= 1'b0;
                    aux_out <= 1'b0;
                    test_out <= 1'b0;
                end
                cal_pkg::CMD_PRIME: prime_out <= 1'b1;
                cal_pkg::CMD_DESTRUCT: destruct_out <= 1'b1;
                cal_pkg::CMD_AUX: aux_out <= 1'b1;
                cal_pkg::CMD_TEST: test_out <= 1'b1;
                default: begin
                end
            endcase
        end
    end

    // Only a reset brings the receiver back after a disable
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rx_disabled <= 1'b0;
        end else if (auth && cmd == cal_pkg::CMD_DISABLE) begin
            rx_disabled <= 1'b1;
        end
    end

    // ****************************************
    // User field and validity window
    // ****************************************
    logic [TMR_W-1:0] valid_tmr_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            user_out <= cal_pkg::USER_RST;
        end else if (auth) begin
            user_out <= frame_reg.user;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            valid_tmr_reg <= '0;
        end else if (auth) begin
            valid_tmr_reg <= TMR_LOAD;
        end else if (valid_tmr_reg != '0) begin
            valid_tmr_reg <= valid_tmr_reg - 1'b1;
        end
    end

    assign data_valid = (valid_tmr_reg != '0);

    // ****************************************
    // Check channel
    // ****************************************
    logic [TMR_W-1:0] chk_tmr_reg;
    logic chk_good;

    assign chk_good = frame_reg.check_bit && site_ok && sender_ok;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chk_tmr_reg <= '0;
        end else if (eval) begin
            chk_tmr_reg <= chk_good ? TMR_LOAD : '0;
        end else if (chk_tmr_reg != '0) begin
            chk_tmr_reg <= chk_tmr_reg - 1'b1;
        end
    end

    assign check_out = (chk_tmr_reg != '0);

    // ****************************************
    // Decode status and telemetry
    // ****************************************
    logic [cal_pkg::SENDER_W-1:0] tlm_sender_reg;
    logic [cal_pkg::CTR_W-1:0] tlm_ctr_reg;

    // Decode-valid ignores the counter so a replay is still visible as addressed
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            decode_valid <= 1'b0;
        end else if (eval) begin
            decode_valid <= ids_ok && code_known;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tlm_sender_reg <= '0;
            tlm_ctr_reg <= cal_pkg::CTR_RST;
        end else if (ctr_clr) begin
            tlm_sender_reg <= frame_reg.sender_identifier;
            tlm_ctr_reg <= cal_pkg::CTR_RST;
        end else if (auth) begin
            tlm_sender_reg <= frame_reg.sender_identifier;
            tlm_ctr_reg <= frame_reg.counter;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tlm_stb <= 1'b0;
        end else begin
            tlm_stb <= eval;
        end
    end

    assign tlm_out = '{
        check_channel: check_out,
        aux: aux_out,
        prime: prime_out,
        destruct: destruct_out,
        decode_valid: decode_valid,
        sender_identifier: tlm_sender_reg,
        counter: tlm_ctr_reg
    };

endmodule

`default_nettype wire

// ==== cal_core_sva.sv ====
// Checker for the command authentication latch, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module cal_core_chk #(
    parameter int FRAME_CYCLES = cal_pkg::FRAME_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Frames
    input wire logic frame_stb,
    input wire logic frame_ready,
    // Watched outputs
    input wire logic prime_out,
    input wire logic destruct_out,
    input wire logic aux_out,
    input wire logic test_out,
    input wire logic rx_disabled,
    input wire logic check_out,
    input wire logic [4:0] user_out,
    input wire logic data_valid,
    input wire logic decode_valid,
    input wire cal_pkg::cal_tlm_s tlm_out,
    input wire logic tlm_stb
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Cycles since the last evaluated frame, saturating
    int age_reg;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            age_reg <= 0;
        end else if (tlm_stb) begin
            age_reg <= 0;
        end else if (age_reg <= FRAME_CYCLES) begin
            age_reg <= age_reg + 1;
        end
    end

    a_eval_once: assert property (frame_stb && frame_ready && !rx_disabled
        |=> !frame_ready ##1 (frame_ready && tlm_stb)) else $error("frame not evaluated once");
    a_tlm_single: assert property (tlm_stb |=> !tlm_stb)
        else $error("telemetry strobe too long");
    a_destruct_prime: assert property ($rose(destruct_out) |-> $past(prime_out) && prime_out)
        else $error("destruct without latched prime");
    a_latch_change: assert property (
        !$stable({prime_out, destruct_out, aux_out, user_out}) |-> tlm_stb)
        else $error("latched output moved outside evaluation");
    // Telemetry words and decode status may only move with an evaluated frame
    a_tlm_mirror: assert property (
        !$stable({tlm_out.sender_identifier, tlm_out.counter, decode_valid}) |-> tlm_stb)
        else $error("telemetry moved outside evaluation");
    a_valid_start: assert property ($rose(data_valid) |-> tlm_stb ##1 data_valid [*8])
        else $error("data valid start or hold wrong");
    a_valid_age: assert property (data_valid && !tlm_stb |-> age_reg < FRAME_CYCLES - 1)
        else $error("data valid held too long");
    a_check_age: assert property (check_out && !tlm_stb |-> age_reg < FRAME_CYCLES - 1)
        else $error("check output held too long");
    a_disabled_quiet: assert property (rx_disabled && $past(rx_disabled) |-> !tlm_stb)
        else $error("frame evaluated while disabled");
    a_disabled_sticky: assert property (rx_disabled |=> rx_disabled)
        else $error("receiver disable released");
    a_reset_off: assert property ($rose(rst_n) |-> !(prime_out || destruct_out || aux_out))
        else $error("command output active after reset");
endmodule

bind cal_core cal_core_chk #(.FRAME_CYCLES(FRAME_CYCLES)) cal_core_chk_inst (
    .mclk(mclk), .rst_n(rst_n), .frame_stb(frame_stb), .frame_ready(frame_ready),
    .prime_out(prime_out), .destruct_out(destruct_out), .aux_out(aux_out),
    .test_out(test_out), .rx_disabled(rx_disabled), .check_out(check_out),
    .user_out(user_out), .data_valid(data_valid), .decode_valid(decode_valid),
    .tlm_out(tlm_out), .tlm_stb(tlm_stb));
`default_nettype wire

// ==== cal_core_tb.sv ====
// Self-checking bench for the command authentication latch
`timescale 1ns/1ps
`default_nettype none

module cal_core_tb;
    // Short frame so the hold windows fit in a quick run
    localparam int FC = 20;
    localparam logic [19:0] TGT = 20'h1_2345;
    localparam logic [15:0] SITE = 16'hbeef;
    logic mclk, rst_n, cfg_load, cfg_counter_en, frame_stb, frame_ready, seen;
    logic prime_out, destruct_out, aux_out, test_out, rx_disabled, check_out;
    logic data_valid, decode_valid, tlm_stb;
    logic [4:0] user_out;
    cal_pkg::cal_frame_s frame_in;
    cal_pkg::cal_tlm_s tlm_out;
    int failures, total_checks;

    cal_tx_model cal_tx_model_inst (.mclk(mclk), .frame_stb(frame_stb), .frame_in(frame_in));
    cal_core #(.FRAME_CYCLES(FC)) cal_core_inst (
        .mclk(mclk), .rst_n(rst_n), .cfg_load(cfg_load), .cfg_target_identifier(TGT),
        .cfg_site_identifier(SITE), .cfg_sender_allow(16'h0028),
        .cfg_counter_en(cfg_counter_en), .frame_stb(frame_stb), .frame_in(frame_in),
        .frame_ready(frame_ready), .prime_out(prime_out), .destruct_out(destruct_out),
        .aux_out(aux_out), .test_out(test_out), .rx_disabled(rx_disabled),
        .check_out(check_out), .user_out(user_out), .data_valid(data_valid),
        .decode_valid(decode_valid), .tlm_out(tlm_out), .tlm_stb(tlm_stb));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic check(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("unexpected at %0t ns: %s", $time, what);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Evaluation lands two cycles after the strobe; three cycles are watched
    task automatic send(input logic [15:0] site, input logic [3:0] snd, input logic [19:0] tgt,
            input logic [11:0] ctr, input logic [5:0] code, input logic [4:0] usr,
            input logic chk);
        cal_tx_model_inst.send(cal_pkg::cal_frame_s'{site, snd, tgt, ctr, code, usr, chk});
        seen = 1'b0;
        repeat (3) begin
            @(posedge mclk);
            #2;
            seen = seen | tlm_stb;
        end
    endtask

    task automatic cmd(input logic [3:0] snd, input logic [11:0] ctr, input logic [5:0] code);
        send(SITE, snd, TGT, ctr, code, 5'h0a, 1'b1);
    endtask

    task automatic configure(input logic cen);
        @(posedge mclk);
        #2;
        cfg_load = 1'b1;
        cfg_counter_en = cen;
        @(posedge mclk);
        #2;
        cfg_load = 1'b0;
    endtask

    task automatic do_reset;
        rst_n = 1'b0;
        repeat (10) @(posedge mclk);
        #2;
        rst_n = 1'b1;
    endtask

    initial begin
        cfg_load = 1'b0;
        cfg_counter_en = 1'b0;
        failures = 0;
        total_checks = 0;
        do_reset();
        check({prime_out, destruct_out, aux_out, data_valid} === 4'h0, "outputs live");
        check(user_out === 5'h00 && frame_ready === 1'b1, "user field or ready");
        $display("test reset done");
        configure(1'b0);
        for (int i = 0; i < 3; i++) begin
            send(i == 0 ? 16'hbeee : SITE, i == 1 ? 4'h4 : 4'h3, i == 2 ? 20'h1_2344 : TGT,
                12'h000, cal_pkg::CMD_PRIME, 5'h15, 1'b1);
            check(prime_out === 1'b0 && user_out === 5'h00 && seen === 1'b1, "bad id");
        end
        send(SITE, 4'h3, TGT, 12'h000, cal_pkg::CMD_PRIME, 5'h15, 1'b1);
        check(prime_out === 1'b1 && user_out === 5'h15 && decode_valid === 1'b1, "good");
        $display("test identifiers done");
        cmd(4'h3, 12'h000, cal_pkg::CMD_DEFAULT);
        check(prime_out === 1'b0 && user_out === 5'h0a, "default did not clear");
        cmd(4'h3, 12'h000, cal_pkg::CMD_DESTRUCT);
        check(destruct_out === 1'b0, "unprimed destruct taken");
        cmd(4'h3, 12'h000, cal_pkg::CMD_PRIME);
        cmd(4'h3, 12'h000, cal_pkg::CMD_DESTRUCT);
        check(destruct_out === 1'b1 && prime_out === 1'b1, "primed destruct");
        cmd(4'h3, 12'h000, cal_pkg::CMD_AUX);
        cmd(4'h3, 12'h000, cal_pkg::CMD_TEST);
        check({aux_out, test_out, destruct_out} === 3'h7, "aux or test");
        cmd(4'h3, 12'h000, 6'h3f);
        check(decode_valid === 1'b0 && aux_out === 1'b1, "unknown code");
        cmd(4'h3, 12'h000, cal_pkg::CMD_DEFAULT);
        check({prime_out, destruct_out, aux_out, test_out} === 4'h0, "default");
        $display("test codes done");
        configure(1'b1);
        cmd(4'h3, 12'h005, cal_pkg::CMD_PRIME);
        check(prime_out === 1'b1 && tlm_out.counter === 12'h005, "counter load");
        check(tlm_out.sender_identifier === 4'h3, "telemetry sender");
        cmd(4'h3, 12'h005, cal_pkg::CMD_AUX);
        check(aux_out === 1'b0, "replayed counter taken");
        cmd(4'h5, 12'h001, cal_pkg::CMD_AUX);
        check(aux_out === 1'b1, "second sender store");
        cmd(4'h3, 12'h006, cal_pkg::CMD_DEFAULT);
        cmd(4'h3, 12'h009, cal_pkg::CMD_DESTRUCT);
        check(destruct_out === 1'b0, "unprimed destruct taken");
        cmd(4'h3, 12'h007, cal_pkg::CMD_PRIME);
        check(prime_out === 1'b1, "rejected destruct stored counter");
        cmd(4'h3, 12'hfff, cal_pkg::CMD_AUX);
        check(aux_out === 1'b1, "signed counter compare");
        cmd(4'h5, 12'h002, cal_pkg::CMD_CTR_CLEAR);
        check(tlm_out.counter === 12'h000, "counter clear");
        cmd(4'h3, 12'h001, cal_pkg::CMD_DEFAULT);
        check(prime_out === 1'b0, "store not cleared");
        $display("test counters done");
        cmd(4'h3, 12'h002, cal_pkg::CMD_AUX);
        // Last cycle of the window, then the first cycle after it
        repeat (FC - 3) @(posedge mclk);
        #2;
        check(data_valid === 1'b1 && check_out === 1'b1, "hold ended early");
        @(posedge mclk);
        #2;
        check(data_valid === 1'b0 && check_out === 1'b0, "hold too long");
        cmd(4'h3, 12'h003, cal_pkg::CMD_AUX);
        check(check_out === 1'b1, "check field on");
        send(SITE, 4'h3, TGT, 12'h004, cal_pkg::CMD_AUX, 5'h00, 1'b0);
        check(check_out === 1'b0 && data_valid === 1'b1, "check field off");
        $display("test frame hold done");
        cmd(4'h3, 12'h005, cal_pkg::CMD_DISABLE);
        check(rx_disabled === 1'b1, "disable code");
        cmd(4'h3, 12'h006, cal_pkg::CMD_PRIME);
        check(seen === 1'b0 && prime_out === 1'b0, "frame after disable");
        do_reset();
        check(rx_disabled === 1'b0 && aux_out === 1'b0, "second reset");
        configure(1'b1);
        cmd(4'h3, 12'h001, cal_pkg::CMD_PRIME);
        check(prime_out === 1'b1, "counter not zero after reset");
        $display("test disable done");
        wrap_up();
    end
endmodule
`default_nettype wire

// ==== cal_ctr_mem.sv ====
// Per-sender last-accepted counter store with registered read and whole-array clear
`timescale 1ns/1ps
`default_nettype none

module cal_ctr_mem #(
    parameter int WIDTH = 12,
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Write and clear
    input wire logic clr_all,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // Read
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem_reg [(1<<ADDR_W)];

    // Every entry is a flop so power-up can zero them all at once
    always_ff @(posedge mclk) begin
        if (!rst_n || clr_all) begin
            for (int i = 0; i < (1 << ADDR_W); i++) begin
                mem_reg[i] <= '0;
            end
        end else if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem_reg[rd_addr];
        end
    end

endmodule

`default_nettype wire

// ==== cal_pkg.sv ====
// Shared widths, codes, timing and carrier types for the command authentication latch
package cal_pkg;

    // ****************************************
    // Field widths
    // ****************************************
    localparam int SITE_W = 16;
    localparam int TARGET_W = 20;
    localparam int SENDER_W = 4;
    localparam int CTR_W = 12;
    localparam int CMD_W = 6;
    localparam int USER_W = 5;
    localparam int SENDER_N = 1 << SENDER_W;

    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [CMD_W-1:0] CMD_DEFAULT = 6'h00;
    localparam logic [CMD_W-1:0] CMD_AUX = 6'h09;
    localparam logic [CMD_W-1:0] CMD_PRIME = 6'h12;
    localparam logic [CMD_W-1:0] CMD_DESTRUCT = 6'h24;
    localparam logic [CMD_W-1:0] CMD_TEST = 6'h03;
    localparam logic [CMD_W-1:0] CMD_DISABLE = 6'h0a;
    localparam logic [CMD_W-1:0] CMD_CTR_CLEAR = 6'h1b;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [USER_W-1:0] USER_RST = 5'h00;
    localparam logic [CTR_W-1:0] CTR_RST = 12'h000;
    localparam logic [TARGET_W-1:0] TARGET_RST = 20'h0_0000;
    localparam logic [SITE_W-1:0] SITE_RST = 16'h0000;
    localparam logic [SENDER_N-1:0] ALLOW_RST = 16'h0000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int FRAME_PERIOD_MS = 20;
    localparam int FRAME_CYCLES = (FRAME_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EVAL = 2'b10
    } cal_state_e;

    typedef struct packed {
        logic [SITE_W-1:0] site_identifier;
        logic [SENDER_W-1:0] sender_identifier;
        logic [TARGET_W-1:0] target_identifier;
        logic [CTR_W-1:0] counter;
        logic [CMD_W-1:0] command;
        logic [USER_W-1:0] user;
        logic check_bit;
    } cal_frame_s;

    typedef struct packed {
        logic check_channel;
        logic aux;
        logic prime;
        logic destruct;
        logic decode_valid;
        logic [SENDER_W-1:0] sender_identifier;
        logic [CTR_W-1:0] counter;
    } cal_tlm_s;

endpackage

// ==== cal_tx_model.sv ====
// Ground sender model: hands one decoded frame per request to the latch
`timescale 1ns/1ps
`default_nettype none

module cal_tx_model (
    // Clock
    input wire logic mclk,
    // Frame output
    output var logic frame_stb,
    output var cal_pkg::cal_frame_s frame_in
);
    initial begin
        frame_stb = 1'b0;
        frame_in = '0;
    end

    // Strobe lasts one cycle; the leading wait keeps strobes two cycles apart
    task automatic send(input cal_pkg::cal_frame_s f);
        @(posedge mclk);
        #2;
        frame_stb = 1'b1;
        frame_in = f;
        @(posedge mclk);
        #2;
        frame_stb = 1'b0;
        // Released lines show the inverse so stale data never looks valid
        frame_in = ~f;
    endtask
endmodule
`default_nettype wire
